// [logic/mce_pkg.sv]
// Purpose: Shared constants for the measurement channel enable registers
// Assumes: 16-bit register words, register index addressing
// Notes:   Offsets, field positions and reset values live here; the monitor and bench repeat offsets and field positions as literals
package mce_pkg;
    localparam int          DATA_WIDTH      = 16;
    localparam int          ADDR_WIDTH      = 8;
    localparam int          CELL_COUNT      = 14;
    localparam int          AUX_COUNT       = 6;
    localparam logic [7:0]  CELL_BLOCK_ADDR = 8'h64;
    localparam logic [7:0]  AUX_FILTER_ADDR = 8'h65;
    localparam int          BLOCK_EN_BIT    = 14;
    localparam int          FILTER_INIT_BIT = 15;
    localparam int          TWO_WIRE_AUXES  = 2;
    localparam logic [13:0] CELL_RESET      = 14'h0000;
    localparam logic [5:0]  AUX_RESET       = 6'h00;
    localparam logic        BIT_RESET       = 1'h0;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;
endpackage

// [logic/mce_aux_gate.sv]
// Purpose: Effective auxiliary measurement enables
// Assumes: Pin-mode inputs are synchronous to sys_clk
// Notes:   Purely combinational; stored values are not altered
`timescale 1ns/10ps
module mce_aux_gate #(
    parameter int AUX_COUNT      = 6,
    parameter int TWO_WIRE_AUXES = 2
) (
    input  wire logic [AUX_COUNT-1:0] auxInputEnable,
    input  wire logic [AUX_COUNT-1:0] auxPinGeneralPurpose,
    input  wire logic                 twoWireControllerEnable,
    output logic      [AUX_COUNT-1:0] auxMeasureEffective
);
    initial begin
        if (TWO_WIRE_AUXES > AUX_COUNT) begin
            $error("TWO_WIRE_AUXES exceeds AUX_COUNT");
        end
    end

    // A pin used as general purpose, or taken by the two-wire controller, is never measured
    always_comb begin
        for (int i = 0; i < AUX_COUNT; i++) begin
            auxMeasureEffective[i] = auxInputEnable[i] & ~auxPinGeneralPurpose[i]
                                   & ~(twoWireControllerEnable && (i < TWO_WIRE_AUXES));
        end
    end
endmodule // mce_aux_gate

// [logic/mce_regs.sv]
// Purpose: Channel enable and filter-initialisation registers for the scan sequencer
// Assumes: Synchronous register port, one access per cycle, read data one cycle later
// Notes:   Sequencer-facing outputs give the effective selection for each scan type
`timescale 1ns/10ps

// Register map
//   Cell/block word: cell enables in the low field, block bit just above.
//   Its top bit has no storage and always reads zero.
//   Aux/filter word: aux enables in the low field, filter
//   initialisation request in the top bit; the gap reads zero.
// Access
//   One access per cycle on the register port. A write lands at
//   the edge that takes it and is readable from the next cycle.
//   A read answers one cycle later with a one-cycle valid pulse.
//   The read word is captured at the request, so it cannot tear
//   if a write follows in the very next cycle.
//   Unmapped addresses ignore writes and read back zero.
// Sequencer side
//   Cell enables go out exactly as stored; ADC and comparator
//   scans share the one cell field.
//   The block channel is only offered while the sequencer says the
//   scan is an ADC scan, so a comparator scan never sees it.
//   The divider switch is driven from a flop so the analog side sees
//   no decode glitches, at the cost of one cycle of latency at the
//   start and end of each scan.
//   Aux enables are masked by pin modes here, never in storage,
//   so software always reads back what it wrote.
//   The filter request is a plain level, not self-clearing;
//   software clears it once the first scan has seeded the filter.
//   Keeping it a level means a request written before a scan
//   cannot be lost if the scan starts late.

// How it works
// - Both registers read and write; select channels
// - Block bit adds block voltage, ADC only
// - Divider follows enabled ADC scan, one cycle late
// - Cell bits include or exclude each cell
// - Init bit zero keeps filter accumulators
// - Init bit one seeds accumulators, first sample
// - Aux bits enable aux inputs for ADC
// - General-purpose pins ignore aux bit, readback kept
// - Two-wire mode ignores aux 1:0, readback kept
module mce_regs #(
    parameter int CELL_COUNT = mce_pkg::CELL_COUNT,
    parameter int AUX_COUNT  = mce_pkg::AUX_COUNT
) (
    input  wire logic                            sys_clk,
    input  wire logic                            reset_n,
    // Register port
    input  wire logic                            regSelect,
    input  wire logic                            regWrite,
    input  wire logic [mce_pkg::ADDR_WIDTH-1:0]  regAddr,
    input  wire logic [mce_pkg::DATA_WIDTH-1:0]  regWriteData,
    output logic      [mce_pkg::DATA_WIDTH-1:0]  regReadData,
    output logic                                 regReadValid,
    // Device configuration
    input  wire logic [AUX_COUNT-1:0]            auxPinGeneralPurpose,
    input  wire logic                            twoWireControllerEnable,
    // Sequencer handshake
    input  wire logic                            scanActive,
    input  wire logic                            scanIsAdc,
    // Sequencer controls
    output logic      [CELL_COUNT-1:0]           cellEnableMask,
    output logic      [AUX_COUNT-1:0]            auxMeasureEnable,
    output logic                                 blockMeasureEnable,
    output logic                                 blockDividerConnect,
    output logic                                 filterInitRequest
);
    // Elaboration checks; the field layout is fixed by the register map
    initial begin
        if (CELL_COUNT != mce_pkg::CELL_COUNT || AUX_COUNT != mce_pkg::AUX_COUNT) begin
            $error("Channel counts must match the register layout");
        end
        if (mce_pkg::BLOCK_EN_BIT != CELL_COUNT) begin
            $error("Block bit must sit just above the cell field");
        end
        if (mce_pkg::FILTER_INIT_BIT <= mce_pkg::BLOCK_EN_BIT) begin
            $error("Filter init bit must sit above the block bit");
        end
        if (mce_pkg::FILTER_INIT_BIT >= mce_pkg::DATA_WIDTH) begin
            $error("Filter init bit lies outside the register word");
        end
        if (AUX_COUNT >= mce_pkg::FILTER_INIT_BIT) begin
            $error("Aux field overlaps the filter init bit");
        end
        if (mce_pkg::TWO_WIRE_AUXES > AUX_COUNT) begin
            $error("Two-wire pins exceed the aux field");
        end
        if (mce_pkg::CELL_BLOCK_ADDR == mce_pkg::AUX_FILTER_ADDR) begin
            $error("Register addresses must differ");
        end
    end

    // Stored fields and write strobes; only the fields hold state, the rest of each word is wired to zero
    logic [CELL_COUNT-1:0] cellEnableStore;
    logic                  blockVoltageEnable;
    logic [AUX_COUNT-1:0]  auxInputEnable;
    logic                  filterInitStore;
    logic                  writeCellBlock;
    logic                  writeAuxFilter;
    // Read decode and the word the read will capture
    logic                  readRequest;
    logic                  readCellBlock;
    logic                  readAuxFilter;
    logic [mce_pkg::DATA_WIDTH-1:0] next_readData;

    // Address decode
    function automatic logic hits(input logic [mce_pkg::ADDR_WIDTH-1:0] a,
                                  input logic [mce_pkg::ADDR_WIDTH-1:0] target);
        return a == target;
    endfunction

    assign writeCellBlock = regSelect & regWrite & hits(regAddr, mce_pkg::CELL_BLOCK_ADDR);
    assign writeAuxFilter = regSelect & regWrite & hits(regAddr, mce_pkg::AUX_FILTER_ADDR);

    // Read decode; address alone picks the word, the strobe gates the capture
    assign readRequest   = regSelect & ~regWrite;
    assign readCellBlock = hits(regAddr, mce_pkg::CELL_BLOCK_ADDR);
    assign readAuxFilter = hits(regAddr, mce_pkg::AUX_FILTER_ADDR);

    // Cell and block enables; bit 15 has no storage so writes vanish
    // Reset clears every field, so no channel is measured until software asks
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cellEnableStore    <= mce_pkg::CELL_RESET;
            blockVoltageEnable <= mce_pkg::BIT_RESET;
        end else if (writeCellBlock) begin
            cellEnableStore    <= regWriteData[CELL_COUNT-1:0];
            blockVoltageEnable <= regWriteData[mce_pkg::BLOCK_EN_BIT];
        end
    end

    // Aux enables and filter init; bits 14 to 6 have no storage
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            auxInputEnable  <= mce_pkg::AUX_RESET;
            filterInitStore <= mce_pkg::BIT_RESET;
        end else if (writeAuxFilter) begin
            auxInputEnable  <= regWriteData[AUX_COUNT-1:0];
            filterInitStore <= regWriteData[mce_pkg::FILTER_INIT_BIT];
        end
    end

    // Word assembly; unstored bits stay zero so writes to them vanish on read
    function automatic logic [mce_pkg::DATA_WIDTH-1:0] packCellWord(input logic [CELL_COUNT-1:0] cells,
                                                                    input logic                  block);
        logic [mce_pkg::DATA_WIDTH-1:0] word;
        word                        = mce_pkg::ZERO_WORD;
        word[CELL_COUNT-1:0]        = cells;
        word[mce_pkg::BLOCK_EN_BIT] = block;
        return word;
    endfunction

    function automatic logic [mce_pkg::DATA_WIDTH-1:0] packAuxWord(input logic [AUX_COUNT-1:0] aux,
                                                                   input logic                 init);
        logic [mce_pkg::DATA_WIDTH-1:0] word;
        word                           = mce_pkg::ZERO_WORD;
        word[AUX_COUNT-1:0]            = aux;
        word[mce_pkg::FILTER_INIT_BIT] = init;
        return word;
    endfunction

    // Read mux; stored values return unchanged regardless of pin modes
    always_comb begin
        next_readData = mce_pkg::ZERO_WORD;
        if (readCellBlock) begin
            next_readData = packCellWord(cellEnableStore, blockVoltageEnable);
        end else if (readAuxFilter) begin
            next_readData = packAuxWord(auxInputEnable, filterInitStore);
        end
    end

    // Registered read answer, one cycle after the request
    // Read data holds between reads so a slow host may take it late
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData  <= mce_pkg::ZERO_WORD;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= readRequest;
            if (readRequest) begin
                regReadData <= next_readData;
            end
        end
    end

    // Divider follows the scan only for ADC scans with the block bit set
    // The divider loads the stack, so it is never left on between scans
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            blockDividerConnect <= 1'b0;
        end else begin
            blockDividerConnect <= blockVoltageEnable & scanActive & scanIsAdc;
        end
    end

    // Enable outputs straight from storage; comparator scans never see the block
    assign cellEnableMask     = cellEnableStore;
    assign blockMeasureEnable = blockVoltageEnable & scanIsAdc;
    assign filterInitRequest  = filterInitStore;

    // Pin-mode masking lives in its own block so the stored aux bits stay untouched
    // and the read path never sees the masked copy
    mce_aux_gate #(
        .AUX_COUNT      (AUX_COUNT),
        .TWO_WIRE_AUXES (mce_pkg::TWO_WIRE_AUXES)
    ) auxGate (
        .auxInputEnable          (auxInputEnable),
        .auxPinGeneralPurpose    (auxPinGeneralPurpose),
        .twoWireControllerEnable (twoWireControllerEnable),
        .auxMeasureEffective     (auxMeasureEnable)
    );
endmodule // mce_regs

// [test/mce_regs_monitor.sv]
// Purpose: Concurrent checks on the channel enable register block
// Assumes: One clock, async active-low reset, idle cycle between reads
// Notes:   Watches ports only; attached by bind
`timescale 1ns/10ps
module mce_regs_monitor #(parameter int CELL_COUNT = 14, parameter int AUX_COUNT = 6) (
    input wire logic sys_clk, reset_n, regSelect, regWrite, regReadValid, twoWireControllerEnable,
    input wire logic scanActive, scanIsAdc, blockMeasureEnable, blockDividerConnect, filterInitRequest,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWriteData, regReadData,
    input wire logic [CELL_COUNT-1:0] cellEnableMask,
    input wire logic [AUX_COUNT-1:0] auxPinGeneralPurpose, auxMeasureEnable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Read decode; one access per cycle, so no write hides behind a read
    wire logic rd = regSelect && !regWrite;
    wire logic rdCell = rd && regAddr == 8'h64;
    wire logic rdAux = rd && regAddr == 8'h65;
    wire logic wrCell = regSelect && regWrite && regAddr == 8'h64;
    wire logic wrAux = regSelect && regWrite && regAddr == 8'h65;
    wire logic [13:0] wrCells = regWriteData[13:0];
    wire logic wrInit = regWriteData[15];
    // Enabled ADC scan with the block bit set
    sequence adc_block_scan; scanActive && scanIsAdc && blockMeasureEnable; endsequence
    read_valid_a: assert property (rd |=> regReadValid) else $error("read not answered");
    no_valid_a: assert property (!rd |=> !regReadValid) else $error("stray read valid");
    block_adc_a: assert property (blockMeasureEnable |-> scanIsAdc) else $error("block outside ADC");
    block_read_a: assert property (rdCell && scanIsAdc |=> regReadData[14] == $past(blockMeasureEnable))
        else $error("block readback wrong");
    divider_on_a: assert property (adc_block_scan |=> blockDividerConnect) else $error("divider open");
    divider_off_a: assert property (!scanActive |=> !blockDividerConnect) else $error("divider left on");
    cell_read_a: assert property (rdCell |=> regReadData[13:0] == cellEnableMask && !regReadData[15])
        else $error("cell readback wrong");
    aux_read_a: assert property (rdAux |=> regReadData[14:6] == 9'h0 && regReadData[15] == filterInitRequest)
        else $error("aux word readback wrong");
    aux_enable_a: assert property (rdAux && !twoWireControllerEnable && auxPinGeneralPurpose == '0
        |=> regReadData[5:0] == $past(auxMeasureEnable)) else $error("aux enable mismatch");
    gpio_mask_a: assert property ((auxMeasureEnable & auxPinGeneralPurpose) == '0) else $error("gpio aux on");
    two_wire_a: assert property (twoWireControllerEnable |-> auxMeasureEnable[1:0] == 2'h0)
        else $error("two-wire aux on");
    unmapped_a: assert property (rd && !rdCell && !rdAux |=> regReadData == 16'h0000)
        else $error("unmapped read not zero");
    cell_write_a: assert property (wrCell |=> cellEnableMask == $past(wrCells))
        else $error("cell write lost");
    init_write_a: assert property (wrAux |=> filterInitRequest == $past(wrInit))
        else $error("init write lost");
endmodule // mce_regs_monitor
bind mce_regs mce_regs_monitor #(.CELL_COUNT(CELL_COUNT), .AUX_COUNT(AUX_COUNT)) i_mon (.sys_clk, .reset_n,
    .regSelect, .regWrite, .regReadValid, .twoWireControllerEnable, .scanActive, .scanIsAdc, .blockMeasureEnable,
    .blockDividerConnect, .filterInitRequest, .regAddr, .regWriteData, .regReadData, .cellEnableMask,
    .auxPinGeneralPurpose, .auxMeasureEnable);

// [test/testbench.sv]
// Purpose: Self-checking bench for the channel enable registers
// Assumes: Inputs change at falling edges
// Notes:   Reads queue their expected word; a watcher compares
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0, reset_n = 1'b0, regSelect = 1'b0, regWrite = 1'b0;
    logic twoWireControllerEnable = 1'b0, scanActive = 1'b0, scanIsAdc = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWriteData = 16'h0000, regReadData, d, expq[$];
    logic [5:0] auxPinGeneralPurpose = 6'h00, auxMeasureEnable;
    logic [13:0] cellEnableMask;
    logic regReadValid, blockMeasureEnable, blockDividerConnect, filterInitRequest;
    logic [31:0] seed = 32'hc850;
    int fails = 0, checked = 0;
    mce_regs i_dut (.sys_clk, .reset_n, .regSelect, .regWrite, .regAddr, .regWriteData, .regReadData,
        .regReadValid, .auxPinGeneralPurpose, .twoWireControllerEnable, .scanActive, .scanIsAdc,
        .cellEnableMask, .auxMeasureEnable, .blockMeasureEnable, .blockDividerConnect, .filterInitRequest);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One access; an idle cycle follows so the strobe never toggles twice at once
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
        @(negedge sys_clk);
        {regSelect, regWrite, regAddr, regWriteData} = {1'b1, w, a, v};
        if (!w) expq.push_back(v);
        @(negedge sys_clk);
        regSelect = 1'b0;
    endtask
    task automatic results;
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #10 sys_clk = ~sys_clk;
    // Valid stands one cycle; look mid-cycle, away from the edge that launches it
    always @(negedge sys_clk) if (regReadValid === 1'b1) chk("readback", regReadData, expq.pop_front());
    // About 400 cycles of work; the 10000-cycle limit means a hang
    initial begin
        #200000;
        fails++;
        results;
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        acc(1'b0, 8'h64, 16'h0000);
        acc(1'b0, 8'h65, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            d = seed[15:0];
            {twoWireControllerEnable, scanIsAdc, auxPinGeneralPurpose} = seed[23:16];
            acc(1'b1, 8'h64, d); // Cells and block bit from the random word; block set whenever d[14] is one
            acc(1'b1, 8'h66, ~d);
            acc(1'b0, 8'h64, d & 16'h7fff);
            acc(1'b0, 8'h66, 16'h0000);
            chk("cells", {2'h0, cellEnableMask}, {2'h0, d[13:0]});
            chk("block", {15'h0, blockMeasureEnable}, {15'h0, d[14] & scanIsAdc});
            acc(1'b1, 8'h65, d);
            acc(1'b0, 8'h65, d & 16'h803f);
            chk("aux", {10'h0, auxMeasureEnable},
                {10'h0, d[5:0] & ~auxPinGeneralPurpose & ~{4'h0, {2{twoWireControllerEnable}}}});
            chk("init", {15'h0, filterInitRequest}, {15'h0, d[15]});
            scanActive = 1'b1; // Init request already written before this scan
            repeat (2) @(negedge sys_clk);
            chk("divider", {15'h0, blockDividerConnect}, {15'h0, d[14] & scanIsAdc});
            scanActive = 1'b0;
            repeat (2) @(negedge sys_clk);
            chk("divider off", {15'h0, blockDividerConnect}, 16'h0000);
        end
        results;
    end
endmodule // testbench
